//--- subtract_swap_defines.svh
// constants for the subtract, swap, secondary page and halt datapath
`ifndef SUBTRACT_SWAP_DEFINES_SVH
`define SUBTRACT_SWAP_DEFINES_SVH

`define DATA_WIDTH          8
`define FILE_ADDR_WIDTH     6
`define FILE_DEPTH          64
`define PAGE_INDEX_WIDTH    4
`define PAGE_DEPTH          16
`define ACC_RESET           8'h00
`define FLAG_RESET          1'h0
`define TIMEOUT_N_RESET     1'h1
`define POWERDOWN_N_RESET   1'h1
`define WDT_WIDTH           8
`define PRESCALER_WIDTH     8
`define WDT_CLEAR           8'h00
`define PRESCALER_CLEAR     8'h00
`define NIBBLE_LOW_MSB      3
`define NIBBLE_HIGH_LSB     4
`define DEST_ACC            1'h0
`define DEST_FILE           1'h1

`endif

//--- subtract_swap_pkg.sv
// types shared by the subtract, swap, secondary page and halt datapath
package subtract_swap_pkg;

   typedef enum logic [2:0]
   {
      op_none,
      op_sub_borrow_from_immediate,
      op_sub_acc_from_file,
      op_nibble_exchange,
      op_store_secondary_page,
      op_load_secondary_page,
      op_halt
   } opcode_type;

   typedef enum logic
   {
      run_state,
      halted_state
   } run_type;

endpackage

//--- secondary_page_mem.sv
// small register file for the secondary special-function page
`timescale 1ns/1ps
`include "subtract_swap_defines.svh"

module secondary_page_mem
#(
   parameter int WIDTH = `DATA_WIDTH,
   parameter int DEPTH = `PAGE_DEPTH,
   parameter int AW    = `PAGE_INDEX_WIDTH
)
(
   // clocking
   input  wire logic             clock,
   input  wire logic             enable,
   // write port
   input  wire logic             write_en,
   input  wire logic [AW-1:0]    write_addr,
   input  wire logic [WIDTH-1:0] write_data,
   // registered read port
   input  wire logic [AW-1:0]    read_addr,
   output logic      [WIDTH-1:0] read_data
);

   logic [WIDTH-1:0] store [DEPTH];

   always_ff @(posedge clock)
   begin
      if (enable && write_en)
      begin
         store[write_addr] <= write_data;
      end
   end

   always_ff @(posedge clock)
   begin
      if (enable)
      begin
         read_data <= store[read_addr];
      end
   end

endmodule

//--- subtract_swap_sfr_halt_ops.sv
// execution datapath for subtract, nibble swap, secondary page moves and halt
`timescale 1ns/1ps
`include "subtract_swap_defines.svh"

// Summary of operation
// - immediate plus inverted accumulator plus carry goes to accumulator in one cycle
// - file value minus accumulator, updates zero, digit carry, carry in one cycle
// - destination bit 0 writes accumulator, 1 writes back to file register
// - file address selects one of 64 locations, 0 to 63
// - swap exchanges nibbles, leaves flags untouched, one cycle
// - store copies accumulator into secondary register 0 to 15 in one cycle
// - load copies secondary register into accumulator, flags untouched
// - halt clears watchdog counter and prescaler then enters halt mode
// - halt sets time-out status high and power-down status low
module subtract_swap_sfr_halt_ops
#(
   parameter int DW = `DATA_WIDTH,
   parameter int FW = `FILE_ADDR_WIDTH,
   parameter int PW = `PAGE_INDEX_WIDTH,
   parameter int WW = `WDT_WIDTH,
   parameter int SW = `PRESCALER_WIDTH
)
(
   // clocking
   input  wire logic                       clock,
   input  wire logic                       rst,
   input  wire logic                       clock_enable,
   // instruction issue
   input  wire logic                       issue,
   input  wire subtract_swap_pkg::opcode_type opcode,
   input  wire logic [DW-1:0]              immediate,
   input  wire logic [FW-1:0]              file_addr,
   input  wire logic                       dest_select,
   input  wire logic [PW-1:0]              page_index,
   // file register operand read
   input  wire logic [DW-1:0]              file_read_data,
   // wake from halt
   input  wire logic                       wake,
   // file register write back
   output logic                            file_write_en,
   output logic      [FW-1:0]              file_write_addr,
   output logic      [DW-1:0]              file_write_data,
   // architectural state
   output logic      [DW-1:0]              accumulator,
   output logic                            carry_flag,
   output logic                            digit_carry_flag,
   output logic                            zero_flag,
   output logic                            timeout_status_n,
   output logic                            powerdown_status_n,
   output logic      [WW-1:0]              watchdog_counter,
   output logic      [SW-1:0]              watchdog_prescaler,
   output logic                            halted,
   output logic                            busy
);

   // ==========================================================
   // arithmetic
   // ==========================================================
   function automatic logic [DW:0] sub_sum(input logic [DW-1:0] a, input logic [DW-1:0] acc, input logic cin);
      sub_sum = {1'b0, a} + {1'b0, ~acc} + {{DW{1'b0}}, cin};
   endfunction

   function automatic logic digit_out(input logic [DW-1:0] a, input logic [DW-1:0] acc, input logic cin);
      logic [4:0] low;
      low = {1'b0, a[3:0]} + {1'b0, ~acc[3:0]} + {4'h0, cin};
      digit_out = low[4];
   endfunction

   logic                          accept;
   logic                          is_imm;
   logic                          is_sub;
   logic [DW-1:0]                 operand;
   logic                          carry_in;
   logic [DW:0]                   next_sum;
   logic [DW-1:0]                 next_swap;
   logic [DW-1:0]                 page_data;
   logic                          load_pending;
   subtract_swap_pkg::run_type    run;

   assign accept    = clock_enable && issue && (run == subtract_swap_pkg::run_state);
   assign is_imm    = (opcode == subtract_swap_pkg::op_sub_borrow_from_immediate);
   assign is_sub    = is_imm || (opcode == subtract_swap_pkg::op_sub_acc_from_file);
   assign operand   = is_imm ? immediate : file_read_data;
   // plain subtract from file has no borrow in: carry-in forced to one for a true difference
   assign carry_in  = is_imm ? carry_flag : 1'b1;
   assign next_sum  = sub_sum(operand, accumulator, carry_in);
   assign next_swap = {file_read_data[`NIBBLE_LOW_MSB:0], file_read_data[DW-1:`NIBBLE_HIGH_LSB]};

   // ==========================================================
   // secondary page
   // ==========================================================
   secondary_page_mem
   #(
      .WIDTH (DW),
      .DEPTH (`PAGE_DEPTH),
      .AW    (PW)
   )
   page_mem
   (
      .clock      (clock),
      .enable     (clock_enable),
      .write_en   (accept && opcode == subtract_swap_pkg::op_store_secondary_page),
      .write_addr (page_index),
      .write_data (accumulator),
      .read_addr  (page_index),
      .read_data  (page_data)
   );

   // memory read is registered, so the load lands one edge later; busy flags that cycle but does not block issue
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         load_pending <= 1'b0;
      end
      else if (clock_enable)
      begin
         load_pending <= accept && (opcode == subtract_swap_pkg::op_load_secondary_page);
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         busy <= 1'b0;
      end
      else if (clock_enable)
      begin
         busy <= accept && (opcode == subtract_swap_pkg::op_load_secondary_page);
      end
   end

   // ==========================================================
   // accumulator and file write back
   // ==========================================================
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         accumulator <= `ACC_RESET;
      end
      else if (clock_enable)
      begin
         if (load_pending)
         begin
            accumulator <= page_data;
         end
         else if (accept && is_imm)
         begin
            accumulator <= next_sum[DW-1:0];
         end
         else if (accept && dest_select == `DEST_ACC)
         begin
            if (opcode == subtract_swap_pkg::op_sub_acc_from_file)
            begin
               accumulator <= next_sum[DW-1:0];
            end
            else if (opcode == subtract_swap_pkg::op_nibble_exchange)
            begin
               accumulator <= next_swap;
            end
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         file_write_en   <= 1'b0;
         file_write_addr <= '0;
         file_write_data <= '0;
      end
      else if (clock_enable)
      begin
         file_write_en <= 1'b0;
         if (accept && dest_select == `DEST_FILE &&
             (opcode == subtract_swap_pkg::op_sub_acc_from_file ||
              opcode == subtract_swap_pkg::op_nibble_exchange))
         begin
            file_write_en   <= 1'b1;
            file_write_addr <= file_addr;
            file_write_data <= (opcode == subtract_swap_pkg::op_nibble_exchange) ? next_swap : next_sum[DW-1:0];
         end
      end
   end

   // ==========================================================
   // flags
   // ==========================================================
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         carry_flag       <= `FLAG_RESET;
         digit_carry_flag <= `FLAG_RESET;
         zero_flag        <= `FLAG_RESET;
      end
      else if (clock_enable && accept && is_sub)
      begin
         carry_flag       <= next_sum[DW];
         digit_carry_flag <= digit_out(operand, accumulator, carry_in);
         zero_flag        <= (next_sum[DW-1:0] == '0);
      end
   end

   // ==========================================================
   // halt, watchdog and power status
   // ==========================================================
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         run <= subtract_swap_pkg::run_state;
      end
      else if (clock_enable)
      begin
         case (run)
            subtract_swap_pkg::run_state:
            begin
               if (accept && opcode == subtract_swap_pkg::op_halt)
               begin
                  run <= subtract_swap_pkg::halted_state;
               end
            end
            subtract_swap_pkg::halted_state:
            begin
               if (wake)
               begin
                  run <= subtract_swap_pkg::run_state;
               end
            end
            default:
            begin
               run <= subtract_swap_pkg::run_state;
            end
         endcase
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         halted <= 1'b0;
      end
      else if (clock_enable)
      begin
         if (accept && opcode == subtract_swap_pkg::op_halt)
         begin
            halted <= 1'b1;
         end
         else if (wake)
         begin
            halted <= 1'b0;
         end
      end
   end

   // watchdog counts freely while running; halt freezes it after the clear
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         watchdog_counter   <= `WDT_CLEAR;
         watchdog_prescaler <= `PRESCALER_CLEAR;
      end
      else if (clock_enable)
      begin
         if (accept && opcode == subtract_swap_pkg::op_halt)
         begin
            watchdog_counter   <= `WDT_CLEAR;
            watchdog_prescaler <= `PRESCALER_CLEAR;
         end
         else if (run == subtract_swap_pkg::run_state)
         begin
            watchdog_prescaler <= watchdog_prescaler + SW'(1);
            if (watchdog_prescaler == '1)
            begin
               watchdog_counter <= watchdog_counter + WW'(1);
            end
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         timeout_status_n   <= `TIMEOUT_N_RESET;
         powerdown_status_n <= `POWERDOWN_N_RESET;
      end
      else if (clock_enable && accept && opcode == subtract_swap_pkg::op_halt)
      begin
         timeout_status_n   <= 1'b1;
         powerdown_status_n <= 1'b0;
      end
   end

endmodule

//--- subtract_swap_sfr_halt_ops_asserts.sv
// concurrent checks on the subtract, swap, page and halt datapath
`timescale 1ns/1ps
module subtract_swap_sfr_halt_ops_asserts
#(
   parameter int DW = 8,
   parameter int FW = 6,
   parameter int WW = 8,
   parameter int SW = 8
)
(
   // instruction side
   input wire logic          clock,
   input wire logic          rst,
   input wire logic          clock_enable,
   input wire logic          issue,
   input wire subtract_swap_pkg::opcode_type opcode,
   input wire logic [DW-1:0] immediate,
   input wire logic [FW-1:0] file_addr,
   input wire logic          dest_select,
   input wire logic [DW-1:0] file_read_data,
   // results
   input wire logic          file_write_en,
   input wire logic [FW-1:0] file_write_addr,
   input wire logic [DW-1:0] file_write_data,
   input wire logic [DW-1:0] accumulator,
   input wire logic          carry_flag,
   input wire logic          digit_carry_flag,
   input wire logic          zero_flag,
   input wire logic          timeout_status_n,
   input wire logic          powerdown_status_n,
   input wire logic [WW-1:0] watchdog_counter,
   input wire logic [SW-1:0] watchdog_prescaler,
   input wire logic          halted,
   input wire logic          busy
);
   // ========
   // helpers
   wire          take  = clock_enable && issue && !halted;
   wire          t_sbc = take && opcode == subtract_swap_pkg::op_sub_borrow_from_immediate;
   wire          t_sub = take && opcode == subtract_swap_pkg::op_sub_acc_from_file;
   wire          t_swp = take && opcode == subtract_swap_pkg::op_nibble_exchange;
   wire          t_ld  = take && opcode == subtract_swap_pkg::op_load_secondary_page;
   wire          t_hlt = take && opcode == subtract_swap_pkg::op_halt;
   wire [2:0]    flags = {carry_flag, digit_carry_flag, zero_flag};
   wire [DW-1:0] swp   = {file_read_data[3:0], file_read_data[7:4]};
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // ========
   // properties
   sequence s_halt_entry;
      halted && watchdog_counter == 8'h00 && watchdog_prescaler == 8'h00;
   endsequence
   // flags must hold through both cycles of the load
   sequence s_load_steps;
      busy && $stable(flags) ##1 !busy && $stable(flags);
   endsequence
   a_halt_clear: assert property (t_hlt |=> s_halt_entry) else $error("halt entry wrong");
   a_halt_status: assert property (t_hlt |=> timeout_status_n && !powerdown_status_n) else $error("halt bits");
   a_load_steps: assert property (t_ld |=> s_load_steps) else $error("load timing");
   a_sbc_result: assert property (t_sbc |=>
      accumulator == $past(immediate) + ~$past(accumulator) + $past(carry_flag)) else $error("sbc result");
   a_sub_result: assert property (t_sub && !dest_select |=>
      accumulator == $past(file_read_data) - $past(accumulator)
      && carry_flag == ($past(file_read_data) >= $past(accumulator))) else $error("sub result");
   a_swap_result: assert property (t_swp |=> $stable(flags)
      && ($past(dest_select) ? file_write_data : accumulator) == $past(swp)) else $error("swap result");
   a_write_back: assert property ((t_sub || t_swp) && dest_select |=>
      file_write_en && file_write_addr == $past(file_addr)) else $error("no write back");
   a_no_write: assert property (take && !dest_select |=> !file_write_en) else $error("stray write");
endmodule

bind subtract_swap_sfr_halt_ops subtract_swap_sfr_halt_ops_asserts #(.DW(DW), .FW(FW), .WW(WW), .SW(SW)) chk_u
(
   .clock              (clock),
   .rst                (rst),
   .clock_enable       (clock_enable),
   .issue              (issue),
   .opcode             (opcode),
   .immediate          (immediate),
   .file_addr          (file_addr),
   .dest_select        (dest_select),
   .file_read_data     (file_read_data),
   .file_write_en      (file_write_en),
   .file_write_addr    (file_write_addr),
   .file_write_data    (file_write_data),
   .accumulator        (accumulator),
   .carry_flag         (carry_flag),
   .digit_carry_flag   (digit_carry_flag),
   .zero_flag          (zero_flag),
   .timeout_status_n   (timeout_status_n),
   .powerdown_status_n (powerdown_status_n),
   .watchdog_counter   (watchdog_counter),
   .watchdog_prescaler (watchdog_prescaler),
   .halted             (halted),
   .busy               (busy)
);

//--- subtract_swap_sfr_halt_ops_tb_top.sv
// self-checking bench for the subtract, swap, page and halt datapath
`timescale 1ns/1ps
module subtract_swap_sfr_halt_ops_tb_top;
   // ========
   // ports and model state
   logic        clock = 1'h0, rst = 1'h1, clock_enable = 1'h1, issue = 1'h0, dest_select = 1'h0, wake = 1'h0;
   logic        file_write_en, carry_flag, digit_carry_flag, zero_flag, timeout_status_n, powerdown_status_n;
   logic        halted, busy, probe = 1'h0, m_c = 1'h0, m_dc = 1'h0, m_z = 1'h0, m_halt = 1'h0;
   logic [3:0]  page_index = 4'h0;
   logic [5:0]  file_addr = 6'h00, file_write_addr;
   logic [7:0]  immediate = 8'h00, file_read_data, file_write_data, accumulator, m_acc = 8'h00;
   logic [7:0]  watchdog_counter, watchdog_prescaler, fmem [64], page [16];
   logic [10:0] aq [$];
   logic [13:0] wq [$];
   logic [18:0] hq [$];
   int          failures = 0, num_checks = 0;
   subtract_swap_pkg::opcode_type opcode = subtract_swap_pkg::op_none;
   assign file_read_data = fmem[file_addr];
   always #5 clock = ~clock;
   subtract_swap_sfr_halt_ops dut_u
   (
      .clock              (clock),
      .rst                (rst),
      .clock_enable       (clock_enable),
      .issue              (issue),
      .opcode             (opcode),
      .immediate          (immediate),
      .file_addr          (file_addr),
      .dest_select        (dest_select),
      .page_index         (page_index),
      .file_read_data     (file_read_data),
      .wake               (wake),
      .file_write_en      (file_write_en),
      .file_write_addr    (file_write_addr),
      .file_write_data    (file_write_data),
      .accumulator        (accumulator),
      .carry_flag         (carry_flag),
      .digit_carry_flag   (digit_carry_flag),
      .zero_flag          (zero_flag),
      .timeout_status_n   (timeout_status_n),
      .powerdown_status_n (powerdown_status_n),
      .watchdog_counter   (watchdog_counter),
      .watchdog_prescaler (watchdog_prescaler),
      .halted             (halted),
      .busy               (busy)
   );
   // ========
   // checking
   task automatic tally(input bit ok);
      num_checks++;
      if (!ok)
      begin
         failures++;
         $display("wrong value at %0t: compare failed", $time);
      end
   endtask
   task automatic chk_state(input logic [10:0] e, g);
      tally(e === g);
   endtask
   task automatic chk_write(input logic [13:0] e, g);
      tally(e === g);
   endtask
   task automatic chk_halt(input logic [18:0] e, g);
      tally(e === g);
   endtask
   task automatic conclude;
      if (aq.size() + wq.size() + hq.size() != 0)
         failures++;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // sampled before the edge's updates land, so this is the settled result
   always @(posedge clock)
   begin
      if (file_write_en === 1'h1)
         chk_write(wq.pop_front(), {file_write_addr, file_write_data});
      if (probe)
         chk_state(aq.pop_front(), {accumulator, carry_flag, digit_carry_flag, zero_flag});
      if (halted === 1'h1 && hq.size() > 0)
         chk_halt(hq.pop_front(), {halted, timeout_status_n, powerdown_status_n, watchdog_counter, watchdog_prescaler});
   end
   // ========
   // stimulus: k picks the operation, v packs immediate, address, destination and page
   task automatic op(input int k, input logic [31:0] v, input int st);
      logic [8:0] s;
      logic [7:0] a, r;
      logic       ci, wr;
      opcode = subtract_swap_pkg::opcode_type'(k + 1);
      immediate = v[7:0];
      file_addr = v[13:8];
      dest_select = v[14];
      page_index = v[18:15];
      issue = 1'h1;
      wr = 1'h0;
      r = fmem[v[13:8]];
      ci = k == 1 ? 1'h1 : m_c;
      a = k == 1 ? r : v[7:0];
      s = a + {1'h0, ~m_acc} + ci;
      if (!m_halt)
      begin
         if (k < 2)
         begin
            m_dc = {1'h0, a[3:0]} + {1'h0, ~m_acc[3:0]} + ci > 5'h0F;
            m_c = s[8];
            m_z = s[7:0] == 8'h00;
         end
         r = k == 2 ? {r[3:0], r[7:4]} : s[7:0];
         if (k == 3)
            page[v[18:15]] = m_acc;
         else if (k == 4)
            m_acc = page[v[18:15]];
         else if (k == 5)
         begin
            hq.push_back(19'h60000);
            m_halt = 1'h1;
         end
         else if (k == 0 || !v[14])
            m_acc = r;
         else
         begin
            wq.push_back({v[13:8], r});
            wr = 1'h1;
         end
      end
      // frozen cycles must show nothing
      if (st > 0)
      begin
         clock_enable = 1'h0;
         repeat (st) @(negedge clock);
         clock_enable = 1'h1;
      end
      @(negedge clock);
      issue = 1'h0;
      if (wr)
         fmem[v[13:8]] = r;
      if (k == 4)
         repeat (2) @(negedge clock);
      aq.push_back({m_acc, m_c, m_dc, m_z});
      probe = 1'h1;
      @(negedge clock);
      probe = 1'h0;
   endtask
   initial
   begin
      void'($urandom(32'h98CDE19F));
      for (int i = 0; i < 64; i++)
         fmem[i] = 8'($urandom);
      repeat (6) @(negedge clock);
      rst = 1'h0;
      for (int i = 0; i < 16; i++)
      begin
         op(0, $urandom, 0);
         op(3, i << 15, 0);
      end
      for (int i = 0; i < 150; i++)
         op($urandom_range(4), $urandom, $urandom_range(2));
      op(5, 0, 0);
      op(0, $urandom, 0);
      wake = 1'h1;
      @(negedge clock);
      wake = 1'h0;
      m_halt = 1'h0;
      repeat (20) op($urandom_range(4), $urandom, 0);
      conclude;
   end
   initial
   begin
      repeat (5000) @(posedge clock);
      failures++;
      conclude;
   end
endmodule
